// File: common/rcs_pkg.sv
// Package of constants and carrier types for the reset and clock switch controller.
package rcs_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] REG_SYSCTL_OFS  = 4'h0;  // system_control_two
	localparam logic [3:0] REG_TRAPCTL_OFS = 4'h4;  // watchdog_control_one trap fields
	localparam logic [3:0] REG_STATUS_OFS  = 4'h8;  // Reset cause and mode status
	localparam logic [3:0] REG_VECTOR_OFS  = 4'hc;  // Reset vector value

	// Field positions in system_control_two.
	localparam int SYSCTL_XTEN_BIT  = 6;  // low_osc_enable
	localparam int SYSCTL_XEN_BIT   = 7;  // high_osc_enable
	localparam int SYSCTL_SYSCK_BIT = 5;  // sysclk_select

	// Field positions in the trap control register.
	localparam int TRAP_TRAP_RAM_AREA_SELECT_BIT = 0;  // trap_ram_area_select
	localparam int TRAP_OUT_BIT  = 1;  // 1 = reset, 0 = interrupt
	localparam int TRAP_SFR_BIT  = 2;  // Trap on fetch from the register area

	// Reset values.
	localparam logic [7:0] SYSCTL_RST  = 8'hc0;  // Both oscillators on, fast clock
	localparam logic [2:0] TRAP_RST    = 3'h6;   // Reset response, register area traps
	localparam logic [15:0] VECTOR_ADDR = 16'hfffe;  // Start vector low byte address

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int FC_PERIODS_MAL   = 24;  // Longest malfunction reset, fc periods
	localparam int MCYC_FC_PERIODS  = 4;   // fc periods per machine cycle
	localparam int PIN_MIN_MCYC     = 3;   // Least pin low time, machine cycles
	localparam logic [4:0] MAL_CYCLES = 5'(FC_PERIODS_MAL - 1);  // Longest rounds down
	localparam logic [4:0] PIN_CYCLES = 5'(PIN_MIN_MCYC * MCYC_FC_PERIODS);
	localparam int SYNC_SLOW_CYCLES = 4;   // Slow to fast clock alignment window
	localparam logic [2:0] SYNC_CYCLES = 3'(SYNC_SLOW_CYCLES);

	// Mode states, Gray along fast -> slow -> sync.
	typedef enum logic [1:0] {
		MODE_FAST = 2'b00,
		MODE_SLOW = 2'b01,
		MODE_SYNC = 2'b11
	} rcs_mode_type;

	// Reset cause bundle.
	typedef struct packed {
		logic pin;
		logic trap;
		logic wdt;
		logic sysclk;
	} rcs_cause_type;

	// Init values driven to the core during reset.
	typedef struct packed {
		logic        master_irq_enable;
		logic [15:0] irq_enable_flags;
		logic [15:0] irq_latches;
		logic        prescaler_clear;
		logic        watchdog_enable;
	} rcs_init_type;

endpackage : rcs_pkg

// File: src/rcs_top.sv
// Reset generation and slow to normal clock switch controller.
`timescale 1ns/10ps

// Behaviour
// - After the clock select is cleared the core stays on the slow clock until both clocks are aligned.
// - A low reset pin leaves slow mode and execution always resumes in the first normal mode.
// - Four reset sources exist, and trap, watchdog and clock fault are malfunction resets.
// - A malfunction reset holds the internal reset for at most 24 fast clock periods.
// - The malfunction detector is not cleared at power-up, so a short spurious reset may occur.
// - Reset loads the counter from the vector, clears interrupt state and prescaler, enables the watchdog.
// - The pin must stay low three machine cycles with a stable oscillator before reset applies.
// - When the pin rises reset is released and execution starts at the vector in the top two bytes.
// - A fetch from the register area, or from RAM when selected, raises an address trap.
// - The trap response is selectable between reset and interrupt, and so is the trap area.
// - At release the vector is read first, then the instruction at its address is fetched.
// - Clearing both oscillators, the fast one on the fast clock, or the slow one on the slow clock resets.
// - Setting the clock select picks the slow clock and clearing it picks the fast clock.
module rcs_top (
	input  wire logic                 clk,            // 25 MHz fast clock
	input  wire logic                 rst_n,          // Power-on reset, active low
	input  wire logic                 reset_pin_n,    // External reset pin, active low
	input  wire logic                 osc_stable,     // Fast oscillator stable
	input  wire logic                 wdt_reset_req,  // Watchdog reset request pulse
	input  wire logic                 fetch_valid,    // Core instruction fetch strobe
	input  wire logic                 fetch_in_sfr,   // Fetch address in register area
	input  wire logic                 fetch_in_ram,   // Fetch address in on-chip RAM
	input  wire logic [3:0]           avs_address,    // Avalon byte address
	input  wire logic                 avs_read,       // Avalon read
	input  wire logic                 avs_write,      // Avalon write
	input  wire logic [31:0]          avs_writedata,  // Avalon write data
	output logic      [31:0]          avs_readdata,   // Avalon read data
	output logic                      avs_waitrequest,// Avalon wait
	output logic                      core_reset_n,   // Internal reset, active low
	output logic                      vector_fetch,   // Reset vector read strobe
	output logic [15:0]               vector_addr,    // Address read during release
	output logic                      use_slow_clk,   // Core runs on the slow clock
	output logic                      high_osc_en,    // Fast oscillator enable
	output logic                      low_osc_en,     // Slow oscillator enable
	output logic                      trap_irq,       // Address trap interrupt pulse
	output rcs_pkg::rcs_init_type     init_values     // Init values during reset
);

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	logic pin_meta_q;
	logic pin_sync_q;
	logic stab_meta_q;
	logic stab_sync_q;

	// Two stages; only the second is read by the low-time counter.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q  <= 1'b1;
			pin_sync_q  <= 1'b1;
			stab_meta_q <= 1'b0;
			stab_sync_q <= 1'b0;
		end else begin
			pin_meta_q  <= reset_pin_n;
			pin_sync_q  <= pin_meta_q;
			stab_meta_q <= osc_stable;
			stab_sync_q <= stab_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Pin low-time counter
	// ------------------------------------------------------------
	logic [4:0] pin_cnt_q;
	logic       pin_rst_q;

	// Glitches shorter than the minimum are ignored; the count restarts when unstable.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_cnt_q <= 5'h00;
			pin_rst_q <= 1'b0;
		end else if (pin_sync_q || !stab_sync_q) begin
			pin_cnt_q <= 5'h00;
			pin_rst_q <= 1'b0;
		end else if (pin_cnt_q < rcs_pkg::PIN_CYCLES - 5'h01) begin
			pin_cnt_q <= pin_cnt_q + 5'h01;
		end else begin
			pin_rst_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] sysctl_q;
	logic [2:0] trapctl_q;
	rcs_pkg::rcs_cause_type cause_q;
	logic       int_rst;

	wire sel_sys  = avs_address == rcs_pkg::REG_SYSCTL_OFS;
	wire sel_trap = avs_address == rcs_pkg::REG_TRAPCTL_OFS;
	wire wr_sys   = avs_write && sel_sys;
	wire [7:0] sys_wd = avs_writedata[7:0];

	// Software write to the clock control; internal reset restores defaults.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sysctl_q  <= rcs_pkg::SYSCTL_RST;
			trapctl_q <= rcs_pkg::TRAP_RST;
		end else if (int_rst) begin
			sysctl_q  <= rcs_pkg::SYSCTL_RST;
			trapctl_q <= rcs_pkg::TRAP_RST;
		end else begin
			if (wr_sys) begin
				sysctl_q <= sys_wd;
			end
			if (avs_write && sel_trap) begin
				trapctl_q <= avs_writedata[2:0];
			end
		end
	end

	assign high_osc_en = sysctl_q[rcs_pkg::SYSCTL_XEN_BIT];
	assign low_osc_en  = sysctl_q[rcs_pkg::SYSCTL_XTEN_BIT];

	// ------------------------------------------------------------
	// Fault detection
	// ------------------------------------------------------------
	logic sysclk_fault;
	logic trap_hit;

	// A faulting write is detected against the bits as they stand before it.
	always_comb begin
		sysclk_fault = 1'b0;
		if (wr_sys) begin
			if (high_osc_en && low_osc_en && !sys_wd[rcs_pkg::SYSCTL_XEN_BIT]
			    && !sys_wd[rcs_pkg::SYSCTL_XTEN_BIT]) begin
				sysclk_fault = 1'b1;
			end else if (!sysctl_q[rcs_pkg::SYSCTL_SYSCK_BIT]
			    && !sys_wd[rcs_pkg::SYSCTL_XEN_BIT]) begin
				sysclk_fault = 1'b1;
			end else if (sysctl_q[rcs_pkg::SYSCTL_SYSCK_BIT]
			    && !sys_wd[rcs_pkg::SYSCTL_XTEN_BIT]) begin
				sysclk_fault = 1'b1;
			end
		end
	end

	// Trap area is the register space when enabled, plus RAM when selected.
	assign trap_hit = fetch_valid && !int_rst &&
	                  ((fetch_in_sfr && trapctl_q[rcs_pkg::TRAP_SFR_BIT]) ||
	                   (fetch_in_ram && trapctl_q[rcs_pkg::TRAP_TRAP_RAM_AREA_SELECT_BIT]));
	wire trap_rst = trap_hit && trapctl_q[rcs_pkg::TRAP_OUT_BIT];

	// Interrupt response is a one-cycle pulse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trap_irq <= 1'b0;
		end else begin
			trap_irq <= trap_hit && !trapctl_q[rcs_pkg::TRAP_OUT_BIT];
		end
	end

	// ------------------------------------------------------------
	// Malfunction reset timer
	// ------------------------------------------------------------
	logic [4:0] mal_cnt_q;
	logic       mal_act_q;
	wire        mal_req = trap_rst || wdt_reset_req || sysclk_fault;

	// Power-up leaves the timer armed, so one short pulse may follow power-on.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mal_act_q <= 1'b1;
			mal_cnt_q <= 5'h00;
		end else if (mal_req && !mal_act_q) begin
			mal_act_q <= 1'b1;
			mal_cnt_q <= 5'h00;
		end else if (mal_act_q) begin
			if (mal_cnt_q >= rcs_pkg::MAL_CYCLES - 5'h01) begin
				mal_act_q <= 1'b0;
			end else begin
				mal_cnt_q <= mal_cnt_q + 5'h01;
			end
		end
	end

	assign int_rst = pin_rst_q || mal_act_q;

	// Cause flags: set by any source; a new event wins over a read clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_q <= '0;
		end else begin
			if (avs_read && avs_address == rcs_pkg::REG_STATUS_OFS && !avs_waitrequest) begin
				cause_q <= '0;
			end
			if (pin_rst_q) cause_q.pin <= 1'b1;
			if (trap_rst) cause_q.trap <= 1'b1;
			if (wdt_reset_req) cause_q.wdt <= 1'b1;
			if (sysclk_fault) cause_q.sysclk <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Clock mode state machine
	// ------------------------------------------------------------
	rcs_pkg::rcs_mode_type mode_q;
	logic [2:0] sync_cnt_q;

	// Clearing the clock select in slow mode goes through an alignment window on the slow clock; internal reset goes straight to fast.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q     <= rcs_pkg::MODE_FAST;
			sync_cnt_q <= 3'h0;
		end else if (int_rst) begin
			mode_q     <= rcs_pkg::MODE_FAST;
			sync_cnt_q <= 3'h0;
		end else begin
			case (mode_q)
				rcs_pkg::MODE_FAST: begin
					if (sysctl_q[rcs_pkg::SYSCTL_SYSCK_BIT]) mode_q <= rcs_pkg::MODE_SLOW;
				end
				rcs_pkg::MODE_SLOW: begin
					if (!sysctl_q[rcs_pkg::SYSCTL_SYSCK_BIT]) begin
						mode_q     <= rcs_pkg::MODE_SYNC;
						sync_cnt_q <= 3'h0;
					end
				end
				rcs_pkg::MODE_SYNC: begin
					if (sync_cnt_q == rcs_pkg::SYNC_CYCLES - 3'h1) begin
						mode_q <= rcs_pkg::MODE_FAST;
					end else begin
						sync_cnt_q <= sync_cnt_q + 3'h1;
					end
				end
				default: mode_q <= rcs_pkg::MODE_FAST;
			endcase
		end
	end

	assign use_slow_clk = mode_q != rcs_pkg::MODE_FAST;

	// ------------------------------------------------------------
	// Release sequence and core outputs
	// ------------------------------------------------------------
	logic rst_q;

	// Vector read is a pulse in the cycle where core_reset_n rises; the core fetches from it next.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q        <= 1'b1;
			core_reset_n <= 1'b0;
			vector_fetch <= 1'b0;
			vector_addr  <= rcs_pkg::VECTOR_ADDR;
			init_values  <= '{1'b0, 16'h0000, 16'h0000, 1'b1, 1'b1};
		end else begin
			rst_q        <= int_rst;
			core_reset_n <= !int_rst;
			vector_fetch <= rst_q && !int_rst;
			vector_addr  <= rcs_pkg::VECTOR_ADDR;
			init_values  <= '{1'b0, 16'h0000, 16'h0000, int_rst, 1'b1};
		end
	end

	// ------------------------------------------------------------
	// Avalon read path
	// ------------------------------------------------------------
	// Writes take no wait state; a read waits one cycle so that the registered data
	// already stands at the edge where waitrequest is seen low. Unmapped offsets read zero.
	logic rd_ack_q;

	assign avs_waitrequest = avs_read && !rd_ack_q;

	// Marks the second cycle of a read, in which the data is handed over.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ack_q <= 1'b0;
		end else begin
			rd_ack_q <= avs_read && !rd_ack_q;
		end
	end

	// Read data is captured in the first cycle of a read and held until the next one.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !rd_ack_q) begin
			case (avs_address)
				rcs_pkg::REG_SYSCTL_OFS:  avs_readdata <= {24'h000000, sysctl_q};
				rcs_pkg::REG_TRAPCTL_OFS: avs_readdata <= {29'h0, trapctl_q};
				rcs_pkg::REG_STATUS_OFS:  avs_readdata <= {26'h0, mode_q, cause_q};
				rcs_pkg::REG_VECTOR_OFS:  avs_readdata <= {16'h0000, rcs_pkg::VECTOR_ADDR};
				default:                  avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : rcs_top

// File: sim/rcs_pin_model.sv
// Model of the external reset source and the fast oscillator status.
`timescale 1ns/10ps
module rcs_pin_model (
	input  wire logic clk,         // Fast clock
	output logic      reset_pin_n, // Reset pin, pulled up when idle
	output logic      osc_stable   // Fast oscillator stable
);
	// The pin idles high on its pull-up and the oscillator starts stable.
	initial begin
		reset_pin_n = 1'b1;
		osc_stable = 1'b1;
	end
	// Holds the pin low for n edges; shorter than 12 must not reset the core.
	task automatic press(input int n, input logic stable);
		osc_stable <= stable;
		reset_pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		reset_pin_n <= 1'b1;
		osc_stable <= 1'b1;
	endtask : press
endmodule : rcs_pin_model

// File: sim/rcs_top_assertions.sv
// Port checker of the reset and clock switch controller.
`timescale 1ns/10ps
module rcs_top_chk (
	input wire logic                  clk,           // Fast clock
	input wire logic                  rst_n,         // Power reset, active low
	input wire logic                  reset_pin_n,   // Reset pin, active low
	input wire logic                  osc_stable,    // Oscillator stable
	input wire logic                  wdt_reset_req, // Watchdog request
	input wire logic                  fetch_valid,   // Fetch strobe
	input wire logic                  fetch_in_sfr,  // Fetch in register area
	input wire logic [3:0]            avs_address,   // Bus address
	input wire logic                  avs_write,     // Bus write
	input wire logic [31:0]           avs_writedata, // Bus write data
	input wire logic                  core_reset_n,  // Internal reset, active low
	input wire logic                  vector_fetch,  // Vector read strobe
	input wire logic [15:0]           vector_addr,   // Vector address
	input wire logic                  use_slow_clk,  // Core on slow clock
	input wire logic                  high_osc_en,   // Fast oscillator enable
	input wire logic                  low_osc_en,    // Slow oscillator enable
	input wire logic                  trap_irq,      // Trap interrupt
	input wire rcs_pkg::rcs_init_type init_values    // Init values
);
	// -----------------------------------------------------------------
	// Helpers and properties
	// -----------------------------------------------------------------
	// A fault is judged on the enables held before the write; clearing both
	// in one write always falls in one of the two cases.
	logic       sel_wr;
	logic       fault;
	logic [2:0] top3;
	assign sel_wr = avs_write && avs_address == 4'h0 && core_reset_n;
	assign top3 = avs_writedata[7:5];
	assign fault = sel_wr && ((high_osc_en && !avs_writedata[7] && !use_slow_clk)
		|| (low_osc_en && !avs_writedata[6] && use_slow_clk));

	default clocking chk_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_slow_select: assert property (sel_wr && top3 == 3'b111
		|-> ##[1:2] use_slow_clk) else $error("slow clock not selected");
	a_sync_hold: assert property (sel_wr && use_slow_clk && top3 == 3'b110
		|-> ##1 use_slow_clk ##[1:8] !use_slow_clk) else $error("clock switch not aligned");
	a_clk_fault: assert property (fault |-> ##2 !core_reset_n)
		else $error("clock fault did not reset");
	a_mal_length: assert property (wdt_reset_req && core_reset_n && reset_pin_n
		|-> ##2 !core_reset_n ##[1:24] core_reset_n) else $error("malfunction reset length");
	a_trap_act: assert property (fetch_valid && fetch_in_sfr && core_reset_n
		|-> ##[1:2] (!core_reset_n || trap_irq)) else $error("register area fetch not trapped");
	a_vector_seq: assert property ($rose(core_reset_n)
		|-> ##[0:2] (vector_fetch && vector_addr == rcs_pkg::VECTOR_ADDR)) else $error("no vector");
	a_normal_after: assert property ($rose(core_reset_n)
		|-> !use_slow_clk && high_osc_en && low_osc_en) else $error("not in normal mode");
	a_init_vals: assert property (!core_reset_n |-> init_values.watchdog_enable
		&& !init_values.master_irq_enable && init_values.irq_enable_flags == 16'h0
		&& init_values.irq_latches == 16'h0) else $error("init values wrong");
	a_pin_reset: assert property ((!reset_pin_n && osc_stable) [*8] ##1
		(!reset_pin_n && osc_stable) [*8] |-> ##1 !core_reset_n) else $error("pin reset missed");
endmodule : rcs_top_chk

bind rcs_top rcs_top_chk rcs_top_chk_inst (.clk, .rst_n, .reset_pin_n, .osc_stable,
	.wdt_reset_req, .fetch_valid, .fetch_in_sfr, .avs_address, .avs_write, .avs_writedata,
	.core_reset_n, .vector_fetch, .vector_addr, .use_slow_clk, .high_osc_en, .low_osc_en,
	.trap_irq, .init_values);

// File: sim/rcs_top_tb_top.sv
// Self-checking bench of the reset and clock switch controller.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
	check_count++; \
	if ((got) !== (ex)) begin \
		fail_count++; \
		$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
	end \
end
module rcs_top_tb_top;
	logic        clk, rst_n, reset_pin_n, osc_stable, wdt_reset_req, fetch_valid;
	logic        fetch_in_sfr, fetch_in_ram, avs_read, avs_write, avs_waitrequest;
	logic        core_reset_n, vector_fetch, use_slow_clk, high_osc_en, low_osc_en, trap_irq;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [15:0] vector_addr;
	rcs_pkg::rcs_init_type init_values;
	int          fail_count = 0, check_count = 0, irq_n = 0, n, i;
	logic [3:0]  ra [5] = '{4'h8, 4'h0, 4'h4, 4'hc, 4'h2};
	logic [31:0] rv [5] = '{32'h0, 32'hc0, 32'h6, 32'hfffe, 32'h0};
	logic [7:0]  flt [3] = '{8'ha0, 8'h40, 8'h00};

	rcs_top rcs_top_inst (.clk, .rst_n, .reset_pin_n, .osc_stable, .wdt_reset_req,
		.fetch_valid, .fetch_in_sfr, .fetch_in_ram, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .core_reset_n, .vector_fetch,
		.vector_addr, .use_slow_clk, .high_osc_en, .low_osc_en, .trap_irq, .init_values);
	rcs_pin_model rcs_pin_model_inst (.clk, .reset_pin_n, .osc_stable);

	// Free-running clock and a tally of trap interrupt pulses.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) irq_n += int'(trap_irq === 1'b1);

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	// A wait that runs out counts as a mismatch and ends the run.
	task automatic bail();
		fail_count++;
		finish_test();
	endtask : bail
	// One bus access; the request holds until waitrequest is seen low.
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
		int k;
		{avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, 24'h0, v};
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) begin
				d = avs_readdata;
				break;
			end
		end
		if (k == 20) bail();
		{avs_write, avs_read} <= 2'b00;
		repeat (2) @(posedge clk);
	endtask : bus
	// Counts the cycles of the next internal reset.
	task automatic low_len();
		int k;
		n = 0;
		for (k = 0; k < 600 && !(core_reset_n === 1'b1 && n > 0); k++) begin
			@(posedge clk);
			n += int'(core_reset_n === 1'b0);
		end
		if (k == 600) bail();
	endtask : low_len
	// Checks the reset length and the cause flag, which the read clears.
	task automatic expect_reset(input logic [31:0] cause);
		low_len();
		`CHK("reset length", 1'b1, n > 0 && n <= 24)
		bus(1'b0, 4'h8, 8'h0);
		`CHK("reset cause", cause, d)
	endtask : expect_reset
	// Pulses watchdog and fetch inputs for one cycle, then lets it settle.
	task automatic pulse(input logic [3:0] v);
		{wdt_reset_req, fetch_valid, fetch_in_sfr, fetch_in_ram} <= v;
		@(posedge clk);
		{wdt_reset_req, fetch_valid, fetch_in_sfr, fetch_in_ram} <= 4'h0;
		repeat (4) @(posedge clk);
	endtask : pulse

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		{wdt_reset_req, fetch_valid, fetch_in_sfr, fetch_in_ram} = 4'h0;
		{avs_read, avs_write, avs_address, avs_writedata} = 38'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		low_len();
		`CHK("power-up reset", 1'b1, n <= 24)
		for (i = 0; i < 5; i++) begin
			bus(1'b0, ra[i], 8'h0);
			if (i > 0) `CHK("register", rv[i], d)
		end
		bus(1'b1, 4'h0, 8'he0);
		`CHK("slow clock", 1'b1, use_slow_clk)
		bus(1'b1, 4'h0, 8'h60);
		`CHK("fast osc off", 1'b0, high_osc_en)
		bus(1'b1, 4'h0, 8'he0);
		repeat (40) @(posedge clk);
		bus(1'b1, 4'h0, 8'hc0);
		`CHK("sync window", 1'b1, use_slow_clk)
		repeat (8) @(posedge clk);
		`CHK("fast clock", 1'b0, use_slow_clk)
		for (i = 0; i < 3; i++) begin
			if (i == 0) bus(1'b1, 4'h0, 8'he0);
			bus(1'b1, 4'h0, flt[i]);
			expect_reset(32'h1);
			`CHK("normal mode", 1'b0, use_slow_clk)
		end
		pulse(4'h8);
		expect_reset(32'h2);
		pulse(4'h6);
		expect_reset(32'h4);
		bus(1'b1, 4'h4, 8'h05);
		pulse(4'h5);
		`CHK("trap interrupt", 2'b11, {irq_n == 1, core_reset_n})
		bus(1'b1, 4'h4, 8'h04);
		pulse(4'h5);
		`CHK("ram area off", 2'b11, {irq_n == 1, core_reset_n})
		bus(1'b0, 4'h8, 8'h0);
		rcs_pin_model_inst.press(4, 1'b1);
		repeat (8) @(posedge clk);
		rcs_pin_model_inst.press(20, 1'b0);
		repeat (8) @(posedge clk);
		bus(1'b0, 4'h8, 8'h0);
		`CHK("no pin reset", 32'h0, d)
		bus(1'b1, 4'h0, 8'he0);
		rcs_pin_model_inst.press(20, 1'b1);
		`CHK("pin reset held", 1'b0, core_reset_n)
		expect_reset(32'h8);
		`CHK("resume fast", 1'b0, use_slow_clk)
		finish_test();
	end
endmodule : rcs_top_tb_top
